// ==== include/swp_regs.vh ====
`ifndef SWP_REGS_VH
`define SWP_REGS_VH

// command opcodes
`define SWP_OP_WRITE_ENABLE   8'h06
`define SWP_OP_GANG_LOCK      8'h7E
`define SWP_OP_GANG_UNLOCK    8'h98
`define SWP_OP_SOLID_PROGRAM  8'hE3
`define SWP_OP_SOLID_ERASE    8'hE4
`define SWP_OP_SOLID_READ     8'hE2
`define SWP_OP_DYN_WRITE      8'hE1
`define SWP_OP_DYN_READ       8'hE0
`define SWP_OP_LOCK_SET       8'hA6
`define SWP_OP_LOCK_READ      8'hA7
`define SWP_OP_PASS_UNLOCK    8'h27
`define SWP_OP_MASK_WRITE     8'hA8

// bytes per complete frame, opcode included; byte indices within a frame, opcode at 0
`define SWP_LEN_OPCODE        4'h1
`define SWP_LEN_MASK          4'h2
`define SWP_LEN_ADDR          4'h5
`define SWP_LEN_DYN           4'h6
`define SWP_LEN_PASS          4'h9
`define SWP_IDX_LAST_ADDR     4'h4
`define SWP_IDX_MASK_DATA     4'h1
`define SWP_IDX_DYN_DATA      4'h5

// lock-flag register layout and mode-select bit (bit 1 of lock_mode_sel_i)
`define SWP_LOCK_FLAG_BIT     0
`define SWP_MODE_PW_BIT       1

// read answers and reset values
`define SWP_BYTE_CLEAR        8'h00
`define SWP_BYTE_SET          8'hFF
`define SWP_SOLID_RESET       1'b0
`define SWP_DYN_RESET         1'b1
`define SWP_MASK_RESET        1'b1

// protection unit map
`define SWP_BLK_LSB           16
`define SWP_SEC_LSB           12
`define SWP_FIRST_BLK         8'h00
`define SWP_LAST_BLK          8'hFF
`define SWP_MID_BASE          9'h00F
`define SWP_TOP_BASE          9'h10E
`define SWP_NUM_UNITS         286
`define SWP_UNIT_W            9

`endif

// ==== design/swp_sync.v ====
`timescale 1ns/10ps
`default_nettype none
module swp_sync #(
   parameter           W       = 1,
   parameter [W-1:0]   RST_VAL = {W{1'b0}}
) (
   // clock and reset
   input  wire         clk_sys_i,
   input  wire         sys_rst_i,
   // async levels in, synced levels out
   input  wire [W-1:0] async_i,
   output reg  [W-1:0] sync_o
);
   reg [W-1:0] meta;

   // first stage feeds only the second stage
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         meta   <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== design/swp_bit_mem.v ====
`timescale 1ns/10ps
`default_nettype none
module swp_bit_mem #(
   parameter             DEPTH = 286,
   parameter             AW    = 9,
   parameter [0:0]       FILL  = 1'b0
) (
   // clock and reset
   input  wire           clk_sys_i,
   input  wire           rst_i,
   // whole-array fill, wins over single write
   input  wire           fill_i,
   input  wire           fill_val_i,
   // single-bit write
   input  wire           we_i,
   input  wire [AW-1:0]  waddr_i,
   input  wire           wdata_i,
   // two registered read ports
   input  wire [AW-1:0]  raddr_a_i,
   output reg            rdata_a_o,
   input  wire [AW-1:0]  raddr_b_i,
   output reg            rdata_b_o
);
   reg [DEPTH-1:0] bits;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         bits      <= {DEPTH{FILL}};
         rdata_a_o <= FILL;
         rdata_b_o <= FILL;
      end else begin
         if (fill_i) begin
            bits <= {DEPTH{fill_val_i}};
         end else if (we_i) begin
            bits[waddr_i] <= wdata_i;
         end
         rdata_a_o <= bits[raddr_a_i];
         rdata_b_o <= bits[raddr_b_i];
      end
   end
endmodule
`default_nettype wire

// ==== design/swp_top.v ====
// Functional notes
// - volatile lock flag in bit 0 gates solid changes
// - reset loads lock flag from mode-select bit 1
// - lock-set command clears lock flag, needs latch
// - solid mode: only reset sets flag again
// - password mode: correct unlock sets flag
// - one solid bit per unit, default zero
// - block program/erase on protected units
// - solid program sets one; erase clears all
// - lock flag zero ignores solid bit changes
// - solid read answers 00h or FFh
// - address bits 31 to 24 ignored
// - dynamic bit per unit, set at reset
// - dynamic write, gang lock/unlock, need latch
// - dynamic read answers 00h or FFh
// - mask flag set at reset, zero hides solid
// - protected if dynamic, or solid and mask
// - gang commands only with advanced select
// - gang opcodes 7Eh/98h, single or quad lanes
// - gang rejected unless chip select on byte boundary
// - scheme only active with advanced select
// - write-protect pin low protects everything with advanced select
`timescale 1ns/10ps
`default_nettype none
`include "swp_regs.vh"
module swp_top (
   // clock and reset
   input  wire        clk_sys_i,
   input  wire        sys_rst_i,
   // serial link pins
   input  wire        sclk_i,
   input  wire        cs_n_i,
   input  wire [3:0]  sio_i,
   output reg  [3:0]  sio_o,
   output reg  [3:0]  sio_oe_o,
   // device state from neighbouring logic
   input  wire        quad_lane_command_mode_i,
   input  wire        advanced_protect_select_i,
   input  wire [1:0]  lock_mode_sel_i,
   input  wire        password_ok_i,
   input  wire        soft_rst_i,
   input  wire        bp_protect_i,
   input  wire        wp_n_i,
   // program/erase protection query
   input  wire        query_valid_i,
   input  wire [23:0] query_addr_i,
   output reg         query_done_o,
   output reg         query_blocked_o,
   // status
   output reg         write_enable_latch_o,
   output reg         solid_lock_flag_o,
   output reg         solid_mask_flag_o
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RECV = 3'b010;
   localparam [2:0] ST_SEND = 3'b100;

   // map a byte address to its protection unit
   function [`SWP_UNIT_W-1:0] swp_unit;
      input [23:0] a;
      begin
         if (a[`SWP_BLK_LSB+7:`SWP_BLK_LSB] == `SWP_FIRST_BLK) begin
            swp_unit = {5'b00000, a[`SWP_SEC_LSB+3:`SWP_SEC_LSB]};
         end else if (a[`SWP_BLK_LSB+7:`SWP_BLK_LSB] == `SWP_LAST_BLK) begin
            swp_unit = `SWP_TOP_BASE + {5'b00000, a[`SWP_SEC_LSB+3:`SWP_SEC_LSB]};
         end else begin
            swp_unit = `SWP_MID_BASE + {1'b0, a[`SWP_BLK_LSB+7:`SWP_BLK_LSB]};
         end
      end
   endfunction

   wire       s_wp_n;
   wire       s_cs_n;
   wire       s_sclk;
   wire [3:0] s_sio;
   reg        prev_cs_n;
   reg        prev_sclk;
   reg  [2:0] state;
   reg  [2:0] bit_cnt;
   reg  [3:0] byte_cnt;
   reg  [7:0] shift_in;
   reg  [7:0] opcode;
   reg  [31:0] addr;
   reg  [7:0] data_byte;
   reg  [2:0] out_cnt;
   reg        rst_v;
   reg        solid_fill;
   reg        solid_we;
   reg        dyn_fill;
   reg        dyn_fill_val;
   reg        dyn_we;
   reg        dyn_wdata;
   reg  [`SWP_UNIT_W-1:0] wr_unit;
   reg        query_q;
   reg        bp_q;
   wire       solid_rd_a;
   wire       solid_rd_b;
   wire       dyn_rd_a;
   wire       dyn_rd_b;
   wire       cs_fall;
   wire       cs_rise;
   wire       sclk_rise;
   wire       sclk_fall;
   wire [2:0] step;
   wire [2:0] next_bit_cnt;
   wire [7:0] next_byte;
   wire       boundary_ok;
   wire       prot_ok;
   wire       is_read;
   reg  [7:0] resp;

   // pins cross into the system clock before any logic sees them
   swp_sync #(
      .W       (7),
      .RST_VAL (7'h60)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({wp_n_i, cs_n_i, sclk_i, sio_i}),
      .sync_o    ({s_wp_n, s_cs_n, s_sclk, s_sio})
   );
   // solid bits survive a software reset
   swp_bit_mem #(
      .DEPTH (`SWP_NUM_UNITS),
      .AW    (`SWP_UNIT_W),
      .FILL  (`SWP_SOLID_RESET)
   ) u_solid (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (sys_rst_i),
      .fill_i     (solid_fill),
      .fill_val_i (`SWP_SOLID_RESET),
      .we_i       (solid_we),
      .waddr_i    (wr_unit),
      .wdata_i    (1'b1),
      .raddr_a_i  (swp_unit(addr[23:0])),
      .rdata_a_o  (solid_rd_a),
      .raddr_b_i  (swp_unit(query_addr_i)),
      .rdata_b_o  (solid_rd_b)
   );
   swp_bit_mem #(
      .DEPTH (`SWP_NUM_UNITS),
      .AW    (`SWP_UNIT_W),
      .FILL  (`SWP_DYN_RESET)
   ) u_dyn (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_v),
      .fill_i     (dyn_fill),
      .fill_val_i (dyn_fill_val),
      .we_i       (dyn_we),
      .waddr_i    (wr_unit),
      .wdata_i    (dyn_wdata),
      .raddr_a_i  (swp_unit(addr[23:0])),
      .rdata_a_o  (dyn_rd_a),
      .raddr_b_i  (swp_unit(query_addr_i)),
      .rdata_b_o  (dyn_rd_b)
   );

   assign cs_fall      = prev_cs_n & ~s_cs_n;
   assign cs_rise      = ~prev_cs_n & s_cs_n;
   assign sclk_rise    = ~prev_sclk & s_sclk & ~s_cs_n;
   assign sclk_fall    = prev_sclk & ~s_sclk & ~s_cs_n;
   assign step         = quad_lane_command_mode_i ? 3'h4 : 3'h1;
   assign next_bit_cnt = bit_cnt + step;
   assign next_byte    = quad_lane_command_mode_i ? {shift_in[3:0], s_sio} : {shift_in[6:0], s_sio[0]};
   assign boundary_ok  = cs_rise & (state == ST_RECV) & (bit_cnt == 3'h0);
   assign prot_ok      = write_enable_latch_o & advanced_protect_select_i;
   assign is_read      = (opcode == `SWP_OP_SOLID_READ) | (opcode == `SWP_OP_DYN_READ);

   always @* begin
      resp = `SWP_BYTE_CLEAR;
      case (opcode)
         `SWP_OP_SOLID_READ: begin
            resp = solid_rd_a ? `SWP_BYTE_SET : `SWP_BYTE_CLEAR;
         end
         `SWP_OP_DYN_READ: begin
            resp = dyn_rd_a ? `SWP_BYTE_SET : `SWP_BYTE_CLEAR;
         end
         `SWP_OP_LOCK_READ: begin
            resp[`SWP_LOCK_FLAG_BIT] = solid_lock_flag_o;
         end
         default: begin
            resp = `SWP_BYTE_CLEAR;
         end
      endcase
   end

   always @(posedge clk_sys_i) begin
      rst_v <= sys_rst_i | soft_rst_i;
   end
   // link framing
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         prev_cs_n <= 1'b1;
         prev_sclk <= 1'b0;
         state     <= ST_IDLE;
         bit_cnt   <= 3'h0;
         byte_cnt  <= 4'h0;
         shift_in  <= 8'h00;
         opcode    <= 8'h00;
         addr      <= 32'h0000_0000;
         data_byte <= 8'h00;
         out_cnt   <= 3'h0;
         sio_o     <= 4'h0;
         sio_oe_o  <= 4'h0;
      end else begin
         prev_cs_n <= s_cs_n;
         prev_sclk <= s_sclk;
         if (cs_rise | s_cs_n) begin
            sio_oe_o <= 4'h0;
         end
         case (state)
            ST_IDLE: begin
               if (cs_fall) begin
                  state    <= ST_RECV;
                  bit_cnt  <= 3'h0;
                  byte_cnt <= 4'h0;
                  out_cnt  <= 3'h0;
               end
            end
            ST_RECV: begin
               if (cs_rise) begin
                  state <= ST_IDLE;
               end else if (sclk_rise) begin
                  shift_in <= next_byte;
                  bit_cnt  <= next_bit_cnt;
                  if (next_bit_cnt == 3'h0) begin
                     if (byte_cnt != 4'hF) begin
                        byte_cnt <= byte_cnt + 4'h1;
                     end
                     if (byte_cnt == 4'h0) begin
                        opcode <= next_byte;
                        if (next_byte == `SWP_OP_LOCK_READ) begin
                           state <= ST_SEND;
                        end
                     end else if (byte_cnt <= `SWP_IDX_LAST_ADDR) begin
                        // upper address byte lands in addr[31:24] and is never used
                        addr <= {addr[23:0], next_byte};
                        if (byte_cnt == `SWP_IDX_LAST_ADDR && is_read) begin
                           state <= ST_SEND;
                        end
                     end
                     if ((byte_cnt == `SWP_IDX_MASK_DATA && opcode == `SWP_OP_MASK_WRITE) ||
                         (byte_cnt == `SWP_IDX_DYN_DATA && opcode == `SWP_OP_DYN_WRITE)) begin
                        data_byte <= next_byte;
                     end
                  end
               end
            end
            ST_SEND: begin
               if (cs_rise) begin
                  state <= ST_IDLE;
               end else if (sclk_fall) begin
                  // answer byte repeats for as long as the clock runs
                  if (quad_lane_command_mode_i) begin
                     sio_o    <= out_cnt[2] ? resp[3:0] : resp[7:4];
                     sio_oe_o <= 4'hF;
                  end else begin
                     sio_o    <= {2'b00, resp[3'h7 - out_cnt], 1'b0};
                     sio_oe_o <= 4'h2;
                  end
                  out_cnt <= out_cnt + step;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // command execution at chip-select release
   always @(posedge clk_sys_i) begin
      solid_fill   <= 1'b0;
      solid_we     <= 1'b0;
      dyn_fill     <= 1'b0;
      dyn_we       <= 1'b0;
      if (rst_v) begin
         write_enable_latch_o <= 1'b0;
         solid_lock_flag_o    <= lock_mode_sel_i[`SWP_MODE_PW_BIT];
         solid_mask_flag_o    <= `SWP_MASK_RESET;
         dyn_fill_val         <= `SWP_DYN_RESET;
         dyn_wdata            <= `SWP_DYN_RESET;
         wr_unit              <= {`SWP_UNIT_W{1'b0}};
      end else if (boundary_ok) begin
         wr_unit   <= swp_unit(addr[23:0]);
         dyn_wdata <= (data_byte != `SWP_BYTE_CLEAR);
         case (opcode)
            `SWP_OP_WRITE_ENABLE: begin
               if (byte_cnt == `SWP_LEN_OPCODE) begin
                  write_enable_latch_o <= 1'b1;
               end
            end
            `SWP_OP_GANG_LOCK, `SWP_OP_GANG_UNLOCK: begin
               if (byte_cnt == `SWP_LEN_OPCODE && prot_ok) begin
                  dyn_fill             <= 1'b1;
                  dyn_fill_val         <= (opcode == `SWP_OP_GANG_LOCK);
                  write_enable_latch_o <= 1'b0;
               end
            end
            `SWP_OP_DYN_WRITE: begin
               if (byte_cnt == `SWP_LEN_DYN && prot_ok) begin
                  dyn_we               <= 1'b1;
                  write_enable_latch_o <= 1'b0;
               end
            end
            `SWP_OP_SOLID_ERASE: begin
               if (byte_cnt == `SWP_LEN_OPCODE && prot_ok) begin
                  solid_fill           <= solid_lock_flag_o;
                  write_enable_latch_o <= 1'b0;
               end
            end
            `SWP_OP_SOLID_PROGRAM: begin
               if (byte_cnt == `SWP_LEN_ADDR && prot_ok) begin
                  solid_we             <= solid_lock_flag_o;
                  write_enable_latch_o <= 1'b0;
               end
            end
            `SWP_OP_LOCK_SET: begin
               if (byte_cnt == `SWP_LEN_OPCODE && prot_ok) begin
                  solid_lock_flag_o    <= 1'b0;
                  write_enable_latch_o <= 1'b0;
               end
            end
            `SWP_OP_PASS_UNLOCK: begin
               if (byte_cnt == `SWP_LEN_PASS && prot_ok) begin
                  // solid mode never reopens the lock from a command
                  if (!lock_mode_sel_i[`SWP_MODE_PW_BIT] && password_ok_i) begin
                     solid_lock_flag_o <= 1'b1;
                  end
                  write_enable_latch_o <= 1'b0;
               end
            end
            `SWP_OP_MASK_WRITE: begin
               if (byte_cnt == `SWP_LEN_MASK && prot_ok) begin
                  solid_mask_flag_o    <= data_byte[0];
                  write_enable_latch_o <= 1'b0;
               end
            end
            default: begin
               write_enable_latch_o <= write_enable_latch_o;
            end
         endcase
      end
   end

   // protection query, two-cycle pipeline through the read port
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         query_q         <= 1'b0;
         bp_q            <= 1'b0;
         query_done_o    <= 1'b0;
         query_blocked_o <= 1'b0;
      end else begin
         query_q      <= query_valid_i;
         bp_q         <= bp_protect_i;
         query_done_o <= query_q;
         if (query_q) begin
            if (advanced_protect_select_i) begin
               query_blocked_o <= ~s_wp_n | dyn_rd_b | (solid_rd_b & solid_mask_flag_o);
            end else begin
               query_blocked_o <= bp_q;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/swp_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module swp_checker (
   // clock and reset
   input wire logic       clk_sys_i,
   input wire logic       sys_rst_i,
   // watched inputs
   input wire logic       cs_n_i,
   input wire logic       soft_rst_i,
   input wire logic       quad_lane_command_mode_i,
   input wire logic       advanced_protect_select_i,
   input wire logic [1:0] lock_mode_sel_i,
   input wire logic       password_ok_i,
   input wire logic       bp_protect_i,
   input wire logic       wp_n_i,
   input wire logic       query_valid_i,
   // watched outputs
   input wire logic [3:0] sio_oe_o,
   input wire logic       query_done_o,
   input wire logic       query_blocked_o,
   input wire logic       write_enable_latch_o,
   input wire logic       solid_lock_flag_o,
   input wire logic       solid_mask_flag_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   property p_done; query_valid_i |-> ##2 query_done_o; endproperty
   a_done: assert property (p_done) else $error("query answer late");
   property p_held; !query_done_o |-> $stable(query_blocked_o); endproperty
   a_held: assert property (p_held) else $error("blocked moved without done");
   property p_bp; query_valid_i && !advanced_protect_select_i |-> ##2 query_blocked_o == $past(bp_protect_i, 2);
   endproperty
   a_bp: assert property (p_bp) else $error("block-protect result not used");
   property p_wp; query_valid_i && advanced_protect_select_i && !$past(wp_n_i) |-> ##2 query_blocked_o;
   endproperty
   a_wp: assert property (p_wp) else $error("write-protect pin ignored");
   property p_rst; $fell(sys_rst_i) |-> solid_mask_flag_o && !write_enable_latch_o
      && solid_lock_flag_o == lock_mode_sel_i[1]; endproperty
   a_rst: assert property (p_rst) else $error("bad volatile reset state");
   property p_hold; !solid_lock_flag_o && lock_mode_sel_i[1] && !soft_rst_i && !$past(soft_rst_i)
      && !$past(soft_rst_i, 2) && !$past(soft_rst_i, 3) |=> !solid_lock_flag_o; endproperty
   a_hold: assert property (p_hold) else $error("lock flag set in solid mode");
   property p_pw; $rose(solid_lock_flag_o) && !lock_mode_sel_i[1] |-> $past(password_ok_i); endproperty
   a_pw: assert property (p_pw) else $error("lock flag set without password");
   // effects land only after cs rises, never deep inside a frame
   property p_frame; (!cs_n_i && !soft_rst_i) [*6] |=> $stable(write_enable_latch_o) && $stable(solid_mask_flag_o);
   endproperty
   a_frame: assert property (p_frame) else $error("state changed mid frame");
   property p_oe; sio_oe_o != 4'h0 |-> sio_oe_o == (quad_lane_command_mode_i ? 4'hF : 4'h2); endproperty
   a_oe: assert property (p_oe) else $error("wrong lanes driven");
   property p_idle; cs_n_i [*6] |-> sio_oe_o == 4'h0; endproperty
   a_idle: assert property (p_idle) else $error("pins driven while deselected");
endmodule
bind swp_top swp_checker swp_checker_i (.clk_sys_i, .sys_rst_i, .cs_n_i, .soft_rst_i, .quad_lane_command_mode_i,
   .advanced_protect_select_i, .lock_mode_sel_i, .password_ok_i, .bp_protect_i, .wp_n_i, .query_valid_i,
   .sio_oe_o, .query_done_o, .query_blocked_o, .write_enable_latch_o, .solid_lock_flag_o, .solid_mask_flag_o);
`default_nettype wire

// ==== tb/swp_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module swp_host_model (
   // lane mode and wire levels
   input  wire logic       quad_i,
   input  wire logic [3:0] pin_i,
   // host-driven link pins
   output var  logic       sclk_o,
   output var  logic       cs_n_o,
   output var  logic [3:0] drv_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      drv_o  = 4'h0;
   end
   // clock stands low outside frames; idle lanes toggle so no stale value
   task automatic frame(input logic [71:0] d, input int nb, input int rb, output logic [7:0] rd);
      int st;
      st = quad_i ? 4 : 1;
      rd = 8'h00;
      cs_n_o = 1'b0;
      for (int i = 0; i < nb; i += st) begin
         drv_o = quad_i ? d[71-i -: 4] : {~drv_o[3:1], d[71-i]};
         #62.5 sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
      end
      for (int i = 0; i < rb; i++) begin
         drv_o = ~drv_o;
         #62.5 sclk_o = 1'b1;
         rd = {rd[6:0], pin_i[1]};
         #62.5 sclk_o = 1'b0;
      end
      // a count off the byte boundary raises cs mid-byte
      #62.5 cs_n_o = 1'b1;
      drv_o = ~drv_o;
      #250;
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   typedef struct {
      logic        wen;
      logic [71:0] d;
      int          nb;
      int          rb;
      logic [7:0]  rx;
      logic [23:0] qa;
      logic        blk;
      logic        write_enable_latch;
   } swp_row_t;
   localparam logic [71:0] WEN = 72'h06_0000000000000000;
   localparam logic [71:0] PASS = 72'h27_0123456789ABCDEF;
   logic        clk_sys_i;
   logic        sys_rst_i;
   logic        quad;
   logic        adv;
   logic [1:0]  lsel;
   logic        pok;
   logic        srst;
   logic        bp;
   logic        wp_n;
   logic        qv;
   logic [23:0] qa;
   wire         sclk;
   wire         cs_n;
   wire  [3:0]  drv;
   wire  [3:0]  pin;
   wire  [3:0]  sio_o;
   wire  [3:0]  sio_oe;
   wire         qd;
   wire         qb;
   wire         write_enable_latch;
   wire         lock;
   wire         mask;
   int          miscompares;
   int          checked;
   logic [7:0]  rd;
   swp_row_t    rows [16] = '{
      '{1'b1, 72'h98_0000000000000000, 8, 0, 8'h00, 24'h001000, 1'b0, 1'b0},
      '{1'b1, 72'hE3_00002000_00000000, 40, 0, 8'h00, 24'h002000, 1'b1, 1'b0},
      '{1'b0, 72'hE2_FF002000_00000000, 40, 8, 8'hFF, 24'h003000, 1'b0, 1'b0},
      '{1'b1, 72'hA8_00_00000000000000, 16, 0, 8'h00, 24'h002000, 1'b0, 1'b0},
      '{1'b1, 72'hA8_01_00000000000000, 16, 0, 8'h00, 24'h002000, 1'b1, 1'b0},
      '{1'b1, 72'hE1_AB050000_01_000000, 48, 0, 8'h00, 24'h05ABCD, 1'b1, 1'b0},
      '{1'b0, 72'hE1_00050000_00_000000, 48, 0, 8'h00, 24'h050000, 1'b1, 1'b0},
      '{1'b0, 72'hE0_00050000_00000000, 40, 8, 8'hFF, 24'h050000, 1'b1, 1'b0},
      '{1'b1, 72'hE1_00050000_00_000000, 48, 0, 8'h00, 24'h050000, 1'b0, 1'b0},
      '{1'b0, 72'hE0_00050000_00000000, 40, 8, 8'h00, 24'h06FFFF, 1'b0, 1'b0},
      '{1'b1, 72'hE4_0000000000000000, 8, 0, 8'h00, 24'h002000, 1'b0, 1'b0},
      '{1'b0, 72'hE2_00002000_00000000, 40, 8, 8'h00, 24'h002000, 1'b0, 1'b0},
      '{1'b1, 72'h7E_0000000000000000, 8, 0, 8'h00, 24'hFFF000, 1'b1, 1'b0},
      '{1'b1, 72'h98_0000000000000000, 9, 0, 8'h00, 24'hFFF000, 1'b1, 1'b1},
      '{1'b1, 72'h98_0000000000000000, 8, 0, 8'h00, 24'hFFF000, 1'b0, 1'b0},
      '{1'b1, 72'hE1_00FFE000_01_000000, 48, 0, 8'h00, 24'hFFE000, 1'b1, 1'b0}
   };
   // the bench resolves the shared data pins
   assign pin = (sio_oe & sio_o) | (~sio_oe & drv);
   swp_top swp_top_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sio_i(pin),
      .sio_o(sio_o), .sio_oe_o(sio_oe), .quad_lane_command_mode_i(quad), .advanced_protect_select_i(adv),
      .lock_mode_sel_i(lsel), .password_ok_i(pok), .soft_rst_i(srst), .bp_protect_i(bp), .wp_n_i(wp_n),
      .query_valid_i(qv), .query_addr_i(qa), .query_done_o(qd), .query_blocked_o(qb),
      .write_enable_latch_o(write_enable_latch), .solid_lock_flag_o(lock), .solid_mask_flag_o(mask));
   swp_host_model swp_host_model_i (.quad_i(quad), .pin_i(pin), .sclk_o(sclk), .cs_n_o(cs_n), .drv_o(drv));
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   task automatic test_done();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      chk_byte(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic send(input logic [71:0] d, input int nb);
      logic [7:0] r;
      swp_host_model_i.frame(d, nb, 0, r);
      @(negedge clk_sys_i);
   endtask
   task automatic query(input logic [23:0] a, input logic e);
      int n;
      @(negedge clk_sys_i);
      qv = 1'b1;
      qa = a;
      @(negedge clk_sys_i);
      qv = 1'b0;
      n = 0;
      while (qd !== 1'b1 && n < 4) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n == 4) begin
         miscompares++;
         test_done();
      end
      chk_bit("blocked", e, qb);
   endtask
   task automatic reset_dut();
      sys_rst_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      miscompares++;
      test_done();
   end
   initial begin
      {quad, qv, pok, srst, bp} = 5'h00;
      {adv, wp_n} = 2'h3;
      lsel = 2'h3;
      qa = 24'h000000;
      reset_dut();
      chk_bit("latch", 1'b0, write_enable_latch);
      chk_bit("lock", 1'b1, lock);
      chk_bit("mask", 1'b1, mask);
      query(24'h001000, 1'b1);
      $display("reset test done");
      foreach (rows[k]) begin
         if (rows[k].wen) send(WEN, 8);
         swp_host_model_i.frame(rows[k].d, rows[k].nb, rows[k].rb, rd);
         if (rows[k].rb != 0) chk_byte("read byte", rows[k].rx, rd);
         query(rows[k].qa, rows[k].blk);
         chk_bit("latch", rows[k].write_enable_latch, write_enable_latch);
         $display("row %0d done", k);
      end
      adv = 1'b0;
      bp = 1'b1;
      query(24'h000000, 1'b1);
      bp = 1'b0;
      query(24'hFFE000, 1'b0);
      send(WEN, 8);
      send(72'h7E_0000000000000000, 8);
      adv = 1'b1;
      chk_bit("latch", 1'b1, write_enable_latch);
      query(24'h001000, 1'b0);
      wp_n = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      query(24'h001000, 1'b1);
      wp_n = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      quad = 1'b1;
      send(72'h7E_0000000000000000, 8);
      quad = 1'b0;
      query(24'h001000, 1'b1);
      $display("mode test done");
      send(WEN, 8);
      send(72'h98_0000000000000000, 8);
      send(WEN, 8);
      send(72'hA6_0000000000000000, 8);
      chk_bit("lock", 1'b0, lock);
      swp_host_model_i.frame(72'hA7_0000000000000000, 8, 8, rd);
      chk_byte("lock byte", 8'h00, rd);
      send(WEN, 8);
      send(72'hE3_00001000_00000000, 40);
      chk_bit("latch", 1'b0, write_enable_latch);
      query(24'h001000, 1'b0);
      pok = 1'b1;
      send(WEN, 8);
      send(PASS, 72);
      chk_bit("lock", 1'b0, lock);
      @(negedge clk_sys_i);
      srst = 1'b1;
      @(negedge clk_sys_i);
      srst = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      chk_bit("lock", 1'b1, lock);
      query(24'h001000, 1'b1);
      lsel = 2'h1;
      pok = 1'b0;
      reset_dut();
      chk_bit("lock", 1'b0, lock);
      send(WEN, 8);
      send(PASS, 72);
      chk_bit("lock", 1'b0, lock);
      pok = 1'b1;
      send(WEN, 8);
      send(PASS, 72);
      chk_bit("lock", 1'b1, lock);
      swp_host_model_i.frame(72'hA7_0000000000000000, 8, 8, rd);
      chk_byte("lock byte", 8'h01, rd);
      $display("lock test done");
      test_done();
   end
endmodule
`default_nettype wire
